/* rtl/ast_ctrl.v */
// analog self-test sequencer with apb register slave
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "ast_regs.vh"
module ast_ctrl #(
  parameter PHASE_CYC = `AST_PHASE_CYC,
  parameter TMO_CYC   = `AST_TMO_CYC
) (
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // device state
  input  wire [1:0]  op_state,
  input  wire        reset_ext,
  input  wire        pwrup_done,
  output wire        go_safe,
  output wire        busy,
  // comparator groups (raw, deglitched, status) and test stimulus
  input  wire [3:0]  cmp_raw,
  input  wire [3:0]  cmp_dgl,
  input  wire [3:0]  cmp_stat,
  output wire [3:0]  test_pulse,
  // enable_drive_irq_pin
  input  wire        irq_pin_i,
  output wire        irq_pin_o,
  output wire        irq_pin_oe
);
  // apb visible registers
  reg  [31:0] rdata_ff;
  reg  [7:0]  ctrl_ff;
  reg  [7:0]  sdly_ff;
  reg  [15:0] wdwin_ff;
  reg  [9:0]  st1_ff;
  reg  [7:0]  st2_ff;
  // sequencer state
  reg  [3:0]  state_ff;
  reg  [3:0]  rem_ff;
  reg  [1:0]  grp_ff;
  reg         second_ff;
  reg         rstrun_ff;
  reg  [33:0] cnt_ff;
  reg         rext_ff;
  // failure reaction and pin drive
  reg         fail_ff;
  reg         irq_low_ff;
  reg         safe_ff;
  reg         pin_ff;
  reg  [3:0]  pulse_ff;
  // next values from combinational logic
  reg  [1:0]  nxt_grp;
  reg         nxt_pin;

  wire        acc = psel & penable;
  wire        wr  = acc & pwrite;
  wire        rd  = acc & ~pwrite;
  wire        hit = (paddr == `AST_OFF_CTRL) | (paddr == `AST_OFF_CFG) |
                    (paddr == `AST_OFF_WDWIN) | (paddr == `AST_OFF_STAT1) |
                    (paddr == `AST_OFF_STAT2) | (paddr == `AST_OFF_STATE);
  wire        wr_ctrl = wr & (paddr == `AST_OFF_CTRL);
  wire [3:0]  starts  = ctrl_ff[`AST_CTRL_START];
  wire        active  = (op_state == `AST_OP_ACTIVE);
  wire        in_safe = (op_state == `AST_OP_SAFE);

  // scheduler interval in cycles, treating window sum as cycles
  // the right shift turns the placed (delay + 1) into (delay + 1) * 256
  // without a multiplier; the product with the window sum stays below 2^33
  wire [33:0] sched_cyc = {8'h00, ({1'b0, sdly_ff} + 9'h001), 17'h00000} >>
                          (17 - `AST_SCHED_MUL) ;
  wire [33:0] sched_tot = sched_cyc * {18'h00000, wdwin_ff};

  // reset-run trigger on start of the output extension
  // rext_ff turns the level into a single-cycle trigger on its rising edge
  wire        rr_trig = reset_ext & ~rext_ff & (op_state == `AST_OP_RESET) &
                        ~ctrl_ff[`AST_CTRL_RRDIS];

  // mcu start: nonzero start bits written outside reset, with scheduler clear or in active
  // only the idle state looks at this, so a write during a run updates the
  // start bits without restarting the sequence
  wire [3:0]  wr_start = pwdata[3:0];
  wire        mcu_go   = wr_ctrl & (|wr_start) & (op_state != `AST_OP_RESET) &
                         (~pwdata[`AST_CTRL_SCHED] | active);

  // steady state of the group under test
  // only the group about to run must be steady; the others may be moving
  wire        steady = (cmp_raw[nxt_grp] == cmp_dgl[nxt_grp]) &
                       (cmp_raw[nxt_grp] == cmp_stat[nxt_grp]);

  // full run in diag/active with overtemp irq enabled toggles the pin
  wire        ot_tog = ~rstrun_ff & (rem_ff[3] | (grp_ff == 2'h3)) &
                       ctrl_ff[`AST_CTRL_OTEN] & ~in_safe &
                       (starts == `AST_ALL_GRP);

  // a recorded failure that must pull the device into safe state; the pin
  // drops on the same edge as the safe request, so the mcu never sees a
  // safe request while the pin still reads high
  wire        fail_act = fail_ff & (rstrun_ff | ~ctrl_ff[`AST_CTRL_RESP]);

  wire [33:0] gap_cyc = (active & ~rstrun_ff) ? sched_tot :
                        {10'h000, `AST_GAP_CYC};
  // phase and time-out lengths are parameters so simulation can shorten them;
  // the counter is wide enough for the longest scheduler interval
  wire [33:0] phase_n = PHASE_CYC;
  wire [33:0] tmo_n   = TMO_CYC;

  // lowest remaining group comes next
  // unselected groups never enter rem_ff, so they are skipped
  always @* begin
    if (rem_ff[0])
      nxt_grp = 2'h0;
    else if (rem_ff[1])
      nxt_grp = 2'h1;
    else if (rem_ff[2])
      nxt_grp = 2'h2;
    else
      nxt_grp = 2'h3;
  end

  // pin level: low in safe, after failure, in the low pin check and overtemp toggles
  always @* begin
    nxt_pin = 1'b1;
    if (in_safe | irq_low_ff | fail_act)
      nxt_pin = 1'b0;
    else if (state_ff == `AST_S_PINLO)
      nxt_pin = 1'b0;
    else if ((state_ff == `AST_S_HI) & (grp_ff == 2'h3) & ot_tog)
      nxt_pin = 1'b0;
  end

  // registers, sequencer and failure reaction
  // one process holds all state, so a set and a clear in one cycle resolve by order
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff   <= 32'h00000000;
      ctrl_ff    <= 8'h00;
      sdly_ff    <= 8'h00;
      wdwin_ff   <= 16'h0001;
      st1_ff     <= 10'h000;
      st2_ff     <= 8'h00;
      state_ff   <= `AST_S_IDLE;
      rem_ff     <= 4'h0;
      grp_ff     <= 2'h0;
      second_ff  <= 1'b0;
      rstrun_ff  <= 1'b0;
      cnt_ff     <= 34'h000000000;
      rext_ff    <= 1'b0;
      fail_ff    <= 1'b0;
      irq_low_ff <= 1'b0;
      safe_ff    <= 1'b0;
      pin_ff     <= 1'b1;
      pulse_ff   <= 4'h0;
    end else begin
      rext_ff  <= reset_ext;
      pin_ff   <= nxt_pin;
      fail_ff  <= 1'b0;
      safe_ff  <= 1'b0;
      pulse_ff <= 4'h0;
      // read data captured in setup phase
      // capturing early keeps prdata stable through the access cycle
      if (psel & ~penable) begin
        case (paddr)
          `AST_OFF_CTRL:  rdata_ff <= {24'h000000, ctrl_ff};
          `AST_OFF_CFG:   rdata_ff <= {24'h000000, sdly_ff};
          `AST_OFF_WDWIN: rdata_ff <= {16'h0000, wdwin_ff};
          `AST_OFF_STAT1: rdata_ff <= {22'h000000, st1_ff};
          `AST_OFF_STAT2: rdata_ff <= {24'h000000, st2_ff};
          `AST_OFF_STATE: rdata_ff <= {24'h000000, rstrun_ff, grp_ff,
                                       state_ff, (state_ff != `AST_S_IDLE)};
          default:        rdata_ff <= 32'h00000000;
        endcase
      end
      // register writes
      if (wr_ctrl) begin
        ctrl_ff[5:0] <= pwdata[5:0];
        ctrl_ff[`AST_CTRL_OTEN] <= pwdata[`AST_CTRL_OTEN];
        // reset-run disable only takes a write once power-up has completed
        if (pwrup_done)
          ctrl_ff[`AST_CTRL_RRDIS] <= pwdata[`AST_CTRL_RRDIS];
      end
      if (wr & (paddr == `AST_OFF_CFG))
        sdly_ff <= pwdata[7:0];
      if (wr & (paddr == `AST_OFF_WDWIN))
        wdwin_ff <= pwdata[15:0];
      // read clears error bits; later sets in this cycle win
      // only bits that the read returned are cleared, so an error recorded
      // between setup and access survives until the next read
      if (rd & (paddr == `AST_OFF_STAT1))
        st1_ff[9:4] <= st1_ff[9:4] & ~rdata_ff[9:4];
      if (rd & (paddr == `AST_OFF_STAT2))
        st2_ff <= st2_ff & ~rdata_ff[7:0];
      if (rd & ((paddr == `AST_OFF_STAT1) | (paddr == `AST_OFF_STAT2)))
        irq_low_ff <= 1'b0;
      // failure reaction one cycle after the error is recorded
      if (fail_act) begin
        safe_ff    <= 1'b1;
        irq_low_ff <= 1'b1;
      end
      // sequencer; groups only cover comparators, never current limits
      // or regulator and supply monitors
      case (state_ff)
        `AST_S_IDLE: begin
          cnt_ff    <= 34'h000000000;
          second_ff <= 1'b0;
          // a reset run has priority over a software start in the same cycle
          if (rr_trig) begin
            rem_ff    <= `AST_ALL_GRP;
            rstrun_ff <= 1'b1;
            state_ff  <= `AST_S_PINLO;
          end else if (mcu_go) begin
            rem_ff    <= wr_start;
            rstrun_ff <= 1'b0;
            state_ff  <= active ? `AST_S_SCHED : `AST_S_WAIT;
          end
        end
        `AST_S_SCHED: begin
          // leaving active or clearing all start bits stops the scheduler
          if (~active | (starts == 4'h0))
            state_ff <= `AST_S_IDLE;
          else if (cnt_ff >= sched_tot - 34'h1) begin
            cnt_ff   <= 34'h000000000;
            state_ff <= `AST_S_WAIT;
          end else
            cnt_ff <= cnt_ff + 34'h1;
        end
        `AST_S_PINLO, `AST_S_PINHI: begin
          // feedback is judged after the propagation wait, low first, then high
          if (cnt_ff[23:0] == `AST_PROP_CYC) begin
            cnt_ff <= 34'h000000000;
            if (irq_pin_i != (state_ff == `AST_S_PINHI)) begin
              st1_ff[`AST_ST1_PIN] <= 1'b1;
              fail_ff <= 1'b1;
            end
            state_ff <= (state_ff == `AST_S_PINLO) ? `AST_S_PINHI :
                        `AST_S_WAIT;
          end else
            cnt_ff <= cnt_ff + 34'h1;
        end
        `AST_S_WAIT: begin
          grp_ff <= nxt_grp;
          st1_ff[nxt_grp] <= 1'b0;
          if (steady) begin
            cnt_ff   <= 34'h000000000;
            // raise the pulse on entry so it lasts the whole high phase
            pulse_ff[nxt_grp] <= 1'b1;
            state_ff <= `AST_S_HI;
          end else if (cnt_ff >= tmo_n - 34'h1) begin
            cnt_ff <= 34'h000000000;
            st1_ff[`AST_ST1_TMO]  <= 1'b1;
            st1_ff[4 + nxt_grp]   <= 1'b1;
            fail_ff  <= 1'b1;
            rem_ff[nxt_grp] <= 1'b0;
            state_ff <= (rem_ff == (4'h1 << nxt_grp)) ? `AST_S_DONE :
                        `AST_S_GAP;
          end else
            cnt_ff <= cnt_ff + 34'h1;
        end
        `AST_S_HI: begin
          // pulse was raised on entry and is held here; the response is
          // judged on the last edge of the phase, where the pulse drops
          pulse_ff[grp_ff] <= 1'b1;
          if (cnt_ff >= phase_n - 34'h1) begin
            cnt_ff <= 34'h000000000;
            pulse_ff[grp_ff] <= 1'b0;
            if (!cmp_raw[grp_ff]) begin
              st2_ff[grp_ff] <= 1'b1;
              st1_ff[4 + grp_ff] <= 1'b1;
              fail_ff <= 1'b1;
            end
            state_ff <= `AST_S_LO;
          end else
            cnt_ff <= cnt_ff + 34'h1;
        end
        `AST_S_LO: begin
          if (cnt_ff >= phase_n - 34'h1) begin
            cnt_ff <= 34'h000000000;
            if (cmp_raw[grp_ff]) begin
              st2_ff[4 + grp_ff] <= 1'b1;
              st1_ff[4 + grp_ff] <= 1'b1;
              fail_ff <= 1'b1;
            end
            // second_ff tells the first pulse of a group from the second
            second_ff <= ~second_ff;
            if (!second_ff)
              state_ff <= `AST_S_GAP;
            else begin
              st1_ff[grp_ff] <= 1'b1;
              rem_ff[grp_ff] <= 1'b0;
              state_ff <= (rem_ff == (4'h1 << grp_ff)) ? `AST_S_DONE :
                          `AST_S_GAP;
            end
          end else
            cnt_ff <= cnt_ff + 34'h1;
        end
        `AST_S_GAP: begin
          // gaps inside a group are short; between groups active uses the scheduler
          if (second_ff) begin
            if (cnt_ff[23:0] >= `AST_GAP_CYC - 24'h1) begin
              cnt_ff   <= 34'h000000000;
              // second pulse starts on entry to the high phase as well
              pulse_ff[grp_ff] <= 1'b1;
              state_ff <= `AST_S_HI;
            end else
              cnt_ff <= cnt_ff + 34'h1;
          end else if (cnt_ff >= gap_cyc - 34'h1) begin
            cnt_ff   <= 34'h000000000;
            state_ff <= `AST_S_WAIT;
          end else
            cnt_ff <= cnt_ff + 34'h1;
        end
        `AST_S_DONE: begin
          cnt_ff    <= 34'h000000000;
          second_ff <= 1'b0;
          if (~rstrun_ff & active & ctrl_ff[`AST_CTRL_SCHED] &
              (starts != 4'h0)) begin
            rem_ff   <= starts;
            state_ff <= `AST_S_SCHED;
          end else begin
            // a single run clears its start bits, unless software is writing
            // them in this very cycle, so that write is not lost
            if (~rstrun_ff & ~wr_ctrl)
              ctrl_ff[`AST_CTRL_START] <= 4'h0;
            rstrun_ff <= 1'b0;
            state_ff  <= `AST_S_IDLE;
          end
        end
        default: state_ff <= `AST_S_IDLE;
      endcase
    end
  end

  // outputs
  assign prdata     = rdata_ff;
  // zero wait states: every access completes in its first access cycle
  assign pready     = 1'b1;
  assign pslverr    = acc & ~hit;
  // single-cycle request; the device state logic latches it
  assign go_safe    = safe_ff;
  assign busy       = (state_ff != `AST_S_IDLE);
  assign test_pulse = pulse_ff;
  assign irq_pin_o  = pin_ff;
  // the pin is push-pull, so its enable stays high
  assign irq_pin_oe = 1'b1;
endmodule

/* rtl/ast_regs.vh */
// register map, field positions, state codes and timing of the analog self-test controller
`ifndef AST_REGS_VH
`define AST_REGS_VH
// byte offsets on apb
`define AST_OFF_CTRL   8'h00
`define AST_OFF_CFG    8'h04
`define AST_OFF_WDWIN  8'h08
`define AST_OFF_STAT1  8'h0C
`define AST_OFF_STAT2  8'h10
`define AST_OFF_STATE  8'h14
// control fields
`define AST_CTRL_START 3:0
`define AST_CTRL_SCHED 4
`define AST_CTRL_RESP  5
`define AST_CTRL_RRDIS 6
`define AST_CTRL_OTEN  7
// status one fields
`define AST_ST1_DONE   3:0
`define AST_ST1_GERR   7:4
`define AST_ST1_TMO    8
`define AST_ST1_PIN    9
// operating states seen on op_state
`define AST_OP_RESET   2'h0
`define AST_OP_DIAG    2'h1
`define AST_OP_ACTIVE  2'h2
`define AST_OP_SAFE    2'h3
// sequencer states
`define AST_S_IDLE     4'h0
`define AST_S_SCHED    4'h1
`define AST_S_PINLO    4'h2
`define AST_S_PINHI    4'h3
`define AST_S_WAIT     4'h4
`define AST_S_HI       4'h5
`define AST_S_LO       4'h6
`define AST_S_GAP      4'h7
`define AST_S_DONE     4'h8
// timing
`define AST_CLK_MHZ    200
`define AST_RUN_US     400
`define AST_TMO_US     112
`define AST_PHASES     16
`define AST_PHASE_CYC  (`AST_RUN_US * `AST_CLK_MHZ / `AST_PHASES)
`define AST_TMO_CYC    (`AST_TMO_US * `AST_CLK_MHZ)
`define AST_GAP_CYC    24'h000003
`define AST_PROP_CYC   24'h000004
`define AST_SCHED_MUL  8
`define AST_ALL_GRP    4'hF
`endif

/* tb/ast_cmp_model.sv */
// comparator and pin feedback model on the far side of the self-test
`timescale 1ns/1ps
module ast_cmp_model (
  // stimulus from the controller
  input  wire [3:0] test_pulse,
  input  wire       pin_o,
  // faults commanded by the bench
  input  wire [3:0] stuck_lo,
  input  wire [3:0] unsteady,
  input  wire       pin_bad,
  // comparator outputs and pin feedback
  output wire [3:0] cmp_raw,
  output wire [3:0] cmp_dgl,
  output wire [3:0] cmp_stat,
  output wire       pin_i
);
  // healthy comparators answer each pulse, a stuck one stays low
  assign cmp_raw  = test_pulse & ~stuck_lo;
  // quiet slow paths keep a resting comparator steady unless told otherwise
  assign cmp_dgl  = unsteady;
  assign cmp_stat = 4'h0;
  // pin feedback, inverted when a driver fault is injected
  assign pin_i    = pin_o ^ pin_bad;
endmodule

/* tb/ast_ctrl_monitor.sv */
// port assertions for the analog self-test controller
`timescale 1ns/1ps
`include "ast_regs.vh"
module ast_ctrl_monitor #(
  parameter PHASE_CYC = 8,
  parameter TMO_CYC   = 20
) (
  // apb
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  // state, comparators and pin
  input wire [1:0]  op_state,
  input wire        go_safe,
  input wire        busy,
  input wire [3:0]  cmp_raw,
  input wire [3:0]  cmp_dgl,
  input wire [3:0]  cmp_stat,
  input wire [3:0]  test_pulse,
  input wire        irq_pin_o
);
  wire       steady = (cmp_raw == cmp_dgl) && (cmp_dgl == cmp_stat);
  reg [15:0] hi_cnt_ff;
  reg [15:0] wait_cnt_ff;
  // length of the current pulse, and of a wait with no pulse outside active
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt_ff   <= 16'h0000;
      wait_cnt_ff <= 16'h0000;
    end else begin
      hi_cnt_ff   <= (|test_pulse) ? hi_cnt_ff + 16'h0001 : 16'h0000;
      wait_cnt_ff <= (busy && !(|test_pulse) && op_state != `AST_OP_ACTIVE) ?
                     wait_cnt_ff + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pulse_onehot: assert property ($onehot0(test_pulse))
    else $error("more than one group pulsed");
  a_pulse_width: assert property ($fell(|test_pulse) |-> hi_cnt_ff == PHASE_CYC)
    else $error("test pulse width wrong");
  a_steady_start: assert property ($rose(|test_pulse) |-> $past(steady))
    else $error("pulse started while unsteady");
  a_wait_bound: assert property (wait_cnt_ff <= TMO_CYC + PHASE_CYC + 16)
    else $error("start wait too long");
  a_safe_pin: assert property (op_state == `AST_OP_SAFE ##1 op_state == `AST_OP_SAFE
    |-> !irq_pin_o)
    else $error("pin high in safe state");
  a_safe_once: assert property (go_safe |=> !go_safe)
    else $error("safe request longer than one cycle");
  a_fail_pin: assert property (go_safe |-> !irq_pin_o)
    else $error("pin not low on failure");
  a_diag_start: assert property (psel && penable && pwrite && paddr == `AST_OFF_CTRL
    && pwdata[3:0] != 4'h0 && !busy && op_state == `AST_OP_DIAG |=> busy)
    else $error("diagnostic run did not start");
  c_fail: cover property (go_safe);
  c_grp4: cover property (test_pulse == 4'h8);
  c_active: cover property (op_state == `AST_OP_ACTIVE && busy);
endmodule
bind ast_ctrl ast_ctrl_monitor #(.PHASE_CYC(PHASE_CYC), .TMO_CYC(TMO_CYC)) mon_u (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .op_state, .go_safe,
  .busy, .cmp_raw, .cmp_dgl, .cmp_stat, .test_pulse, .irq_pin_o);

/* tb/ast_ctrl_tb_top.sv */
// self-checking bench for the analog self-test controller
`timescale 1ns/1ps
`include "ast_regs.vh"
module ast_ctrl_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  op_state;
  logic        reset_ext, pwrup_done, go_safe, busy, irq_pin_i, irq_pin_o, irq_pin_oe, pin_bad;
  logic [3:0]  cmp_raw, cmp_dgl, cmp_stat, test_pulse, stuck_lo, unsteady, m, done_e;
  logic [31:0] exp_q[$], msk_q[$];
  int          miscompares, tests_run, n_safe, seed, n0;
  wire         pin_lvl = irq_pin_oe ? irq_pin_o : 1'b1; // pulled up when released

  ast_ctrl #(.PHASE_CYC(8), .TMO_CYC(20)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .op_state, .reset_ext, .pwrup_done,
    .go_safe, .busy, .cmp_raw, .cmp_dgl, .cmp_stat, .test_pulse, .irq_pin_i, .irq_pin_o,
    .irq_pin_oe);
  ast_cmp_model cmp_u (.test_pulse, .pin_o(pin_lvl), .stuck_lo, .unsteady, .pin_bad,
    .cmp_raw, .cmp_dgl, .cmp_stat, .pin_i(irq_pin_i));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] e);
    tests_run++;
    if (seen !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one apb transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k);
    exp_q.push_back(e & k);
    msk_q.push_back(k);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (2) @(posedge pclk);
    while (busy !== 1'b0 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    check("busy", {31'h0, busy}, 32'h0);
  endtask

  // each completed read takes the oldest note off the queue
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      check("prdata", prdata & msk_q.pop_front(), exp_q.pop_front());

  // every completed transfer flags an error exactly when its word is unmapped
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
      check("pslverr", {31'h0, pslverr}, {31'h0, paddr > `AST_OFF_STATE});

  always @(posedge pclk)
    if (go_safe === 1'b1)
      n_safe++;

  initial begin
    repeat (60000) @(posedge pclk);
    miscompares++;
    $display("ERROR watchdog expired");
    finish_test();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {reset_ext, pwrup_done, stuck_lo, unsteady, pin_bad, done_e} = '0;
    op_state = `AST_OP_DIAG;
    presetn = 1'b0;
    seed = 87480;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(`AST_OFF_CTRL, 32'h0, 32'hFF);
    rd(`AST_OFF_WDWIN, 32'h1, 32'hFFFF);
    rd(8'h18, 32'h0, 32'hFFFFFFFF);
    wr(`AST_OFF_CTRL, 32'h40);
    rd(`AST_OFF_CTRL, 32'h0, 32'hFF);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      m = 4'($random(seed));
      if (i == 3 || m == 4'h0) m = 4'hF;
      wr(`AST_OFF_CTRL, {28'h0, m});
      wait_idle();
      done_e = done_e | m;
      rd(`AST_OFF_STAT1, {28'h0, done_e}, 32'h3FF);
      rd(`AST_OFF_CTRL, 32'h0, 32'hF);
    end
    // full run with the overtemperature interrupt enabled pulls the pin low in group four
    wr(`AST_OFF_CTRL, 32'h8F);
    for (int k = 0; k < 400 && test_pulse !== 4'h8; k++) @(posedge pclk);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    check("pin", {31'h0, irq_pin_o}, 32'h0);
    wait_idle();
    @(negedge pclk);
    check("pin", {31'h0, irq_pin_o}, 32'h1);
    rd(`AST_OFF_STAT1, {28'h0, done_e}, 32'h3FF);
    $display("test diagnostic runs done");
    stuck_lo <= 4'h1;
    for (int r = 0; r < 2; r++) begin
      n0 = n_safe;
      wr(`AST_OFF_CTRL, 32'h1 | (r << 5));
      wait_idle();
      @(negedge pclk);
      // a stuck group fails both of its pulses; with the response bit clear each failure asks for safe state
      check("go_safe count", 32'(n_safe - n0), (r == 0) ? 32'h2 : 32'h0);
      check("pin", {31'h0, irq_pin_o}, 32'(r));
      rd(`AST_OFF_STAT1, {24'h0, 4'h1, done_e}, 32'h3FF);
      rd(`AST_OFF_STAT2, 32'h01, 32'hFF);
      rd(`AST_OFF_STAT1, {28'h0, done_e}, 32'h3FF);
      @(negedge pclk);
      check("pin", {31'h0, irq_pin_o}, 32'h1);
    end
    stuck_lo <= 4'h0;
    unsteady <= 4'h2;
    wr(`AST_OFF_CTRL, 32'h22);
    wait_idle();
    rd(`AST_OFF_STAT1, 32'h100, 32'h100);
    $display("test failures done");
    unsteady <= 4'h0;
    op_state <= `AST_OP_RESET;
    for (int b = 0; b < 2; b++) begin
      n0 = n_safe;
      pin_bad <= b[0];
      reset_ext <= 1'b0;
      @(posedge pclk);
      reset_ext <= 1'b1;
      wait_idle();
      rd(`AST_OFF_STAT1, {22'h0, b[0], 5'h0, 4'hF}, 32'h20F);
      @(negedge pclk);
      check("go_safe count", 32'(n_safe - n0), 32'(b));
    end
    pin_bad <= 1'b0;
    pwrup_done <= 1'b1;
    wr(`AST_OFF_CTRL, 32'h40);
    reset_ext <= 1'b0;
    @(posedge pclk);
    reset_ext <= 1'b1;
    repeat (3) @(posedge pclk);
    check("busy", {31'h0, busy}, 32'h0);
    $display("test reset runs done");
    op_state <= `AST_OP_ACTIVE;
    wr(`AST_OFF_CFG, 32'h0);
    wr(`AST_OFF_CTRL, 32'h8);
    repeat (200) @(posedge pclk);
    check("pulse", {28'h0, test_pulse}, 32'h0);
    wait_idle();
    rd(`AST_OFF_STAT1, 32'hF, 32'h3FF);
    wr(`AST_OFF_CTRL, 32'h18);
    repeat (700) @(posedge pclk);
    check("busy", {31'h0, busy}, 32'h1);
    wr(`AST_OFF_CTRL, 32'h10);
    wait_idle();
    op_state <= `AST_OP_SAFE;
    wr(`AST_OFF_CTRL, 32'h1);
    wait_idle();
    @(negedge pclk);
    check("pin", {31'h0, irq_pin_o}, 32'h0);
    $display("test active and safe done");
    finish_test();
  end
endmodule
